//--- include/rox_pkg.sv
// constants for the radar object extended and warning frame codec
package rox_pkg;
	localparam logic [10:0] EXT_FRAME_ID = 11'h60d;
	localparam logic [10:0] WARN_FRAME_ID = 11'h60e;
	localparam logic [3:0] EXT_DLC = 4'h8;
	localparam logic [3:0] WARN_DLC = 4'h2;
	// field start bits (lsb position, big-endian numbering) and lengths
	localparam int ID_START = 0;
	localparam int ID_LEN = 8;
	localparam int LONG_START = 21;
	localparam int LONG_LEN = 11;
	localparam int CLASS_START = 24;
	localparam int CLASS_LEN = 3;
	localparam int LAT_START = 28;
	localparam int LAT_LEN = 9;
	localparam int HEAD_START = 46;
	localparam int HEAD_LEN = 10;
	localparam int LEN_START = 48;
	localparam int LEN_LEN = 8;
	localparam int WID_START = 56;
	localparam int WID_LEN = 8;
	localparam int MASK_START = 8;
	localparam int MASK_LEN = 8;
	localparam int OBJ_W = 65;
	localparam int FIFO_DEPTH = 16;
	// object classes
	localparam logic [2:0] CLS_POINT = 3'h0;
	localparam logic [2:0] CLS_CAR = 3'h1;
	localparam logic [2:0] CLS_TRUCK = 3'h2;
	localparam logic [2:0] CLS_UNUSED = 3'h3;
	localparam logic [2:0] CLS_MOTORCYCLE = 3'h4;
	localparam logic [2:0] CLS_BICYCLE = 3'h5;
	localparam logic [2:0] CLS_WIDE = 3'h6;
	localparam logic [2:0] CLS_RESERVED = 3'h7;
	// quality code table, upper half, bounds in thousandths
	localparam logic [4:0] QUAL_FIRST = 5'h0d;
	localparam logic [4:0] QUAL_LAST = 5'h1e;
	localparam logic [4:0] QUAL_INVALID = 5'h1f;
	localparam int QUAL_ROWS = 18;
	localparam logic [17:0] QB_HEAD [QUAL_ROWS] = '{
		18'h001d7, 18'h0029d, 18'h003b5, 18'h00542, 18'h00775, 18'h00a95,
		18'h00f03, 18'h0154b, 18'h01e36, 18'h02adb, 18'h03ccd, 18'h05641,
		18'h07a5d, 18'h0ad97, 18'h0f644, 18'h15d5d, 18'h1efa1, 18'h2bf20};
	localparam logic [13:0] QB_OTHER [QUAL_ROWS] = '{
		14'h0087, 14'h00ae, 14'h00e0, 14'h0120, 14'h0173, 14'h01de,
		14'h0268, 14'h031a, 14'h03ff, 14'h0525, 14'h06a1, 14'h088b,
		14'h0b01, 14'h0e2e, 14'h1244, 14'h1789, 14'h1e52, 14'h2710};
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_EXT, ST_WARN} rox_state_t;
endpackage

//--- core/rox_fifo.sv
// object fifo with registered read data
`timescale 1ns/1ps
module rox_fifo #(
	parameter int WIDTH = 65,
	parameter int DEPTH = 16
) (
	input wire logic clk_in, // clock
	input wire logic rst_in, // sync reset
	input wire logic in_valid_in, // write request
	output logic in_ready_out, // room left
	input wire logic [WIDTH-1:0] in_data_in, // write word
	output logic out_valid_out, // word available
	input wire logic out_ready_in, // drain accepts
	output logic [WIDTH-1:0] out_data_out // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic out_valid;
	logic [WIDTH-1:0] out_data;
	wire push = in_valid_in && in_ready_out;
	wire pop = out_valid && out_ready_in;
	wire [AW-1:0] next_rd = rd_ptr + AW'(pop);
	wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);
	// bypass covers a word written into the slot that becomes the head
	wire bypass = push && (wr_ptr == next_rd);
	assign in_ready_out = (count != (AW+1)'(DEPTH));
	assign out_valid_out = out_valid;
	assign out_data_out = out_data;
	always_ff @(posedge clk_in) begin
		if (push) begin
			mem[wr_ptr] <= in_data_in;
		end
		out_data <= bypass ? in_data_in : mem[next_rd];
	end
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			out_valid <= 1'b0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= next_rd;
			count <= next_count;
			out_valid <= (next_count != '0);
		end
	end
endmodule

//--- core/rox_codec.sv
// radar object extended-information and collision-warning frame codec
`timescale 1ns/1ps
module rox_codec (
	input wire logic clk_in, // 25 mhz clock
	input wire logic rst_in, // sync reset, active high
	input wire logic ext_info_send_enable_in, // send extended frames
	input wire logic coll_det_enable_in, // collision detection active
	input wire logic obj_valid_in, // object offered
	output logic obj_ready_out, // object fifo has room
	input wire logic [7:0] track_identifier_in, // object track id
	input wire logic [10:0] long_rel_accel_in, // raw longitudinal accel
	input wire logic [2:0] obj_class_in, // object class
	input wire logic [8:0] lat_rel_accel_in, // raw lateral accel
	input wire logic [9:0] heading_angle_in, // raw heading angle
	input wire logic [7:0] obj_length_in, // raw length
	input wire logic [7:0] obj_width_in, // raw width
	input wire logic [7:0] collision_region_mask_in, // region hit bits
	output logic tx_valid_out, // frame offered to can
	input wire logic tx_ready_in, // can takes frame
	output logic [10:0] tx_id_out, // frame identifier
	output logic [3:0] tx_dlc_out, // frame length in bytes
	output logic [63:0] tx_data_out, // payload, byte k in bits 8k+7..8k
	input wire logic rx_valid_in, // received frame strobe
	input wire logic [10:0] rx_id_in, // received identifier
	input wire logic [63:0] rx_data_in, // received payload
	output logic rx_ext_valid_out, // extended frame decoded
	output logic rx_warn_valid_out, // warning frame decoded
	output logic [7:0] rx_track_identifier_out, // decoded track id
	output logic [10:0] rx_long_rel_accel_out, // decoded longitudinal accel
	output logic [2:0] rx_obj_class_out, // decoded class
	output logic [8:0] rx_lat_rel_accel_out, // decoded lateral accel
	output logic [9:0] rx_heading_angle_out, // decoded heading
	output logic [7:0] rx_obj_length_out, // decoded length
	output logic [7:0] rx_obj_width_out, // decoded width
	output logic [7:0] rx_collision_region_mask_out, // decoded region bits
	input wire logic [4:0] qual_code_in, // quality code to look up
	output logic [17:0] qual_heading_bound_out, // heading bound, millidegrees
	output logic [13:0] qual_other_bound_out, // other bound, thousandths
	output logic qual_in_table_out, // code within upper half
	output logic qual_invalid_out // code marks invalid
);
	// big-endian numbering: a field runs upward in its byte, then on in the
	// byte before it, so bit 7 of byte k is followed by bit 0 of byte k-1
	function automatic logic [63:0] put_field(input logic [63:0] d, input int start,
		input int len, input logic [15:0] v);
		logic [63:0] r;
		int p;
		r = d;
		p = start;
		for (int i = 0; i < 16; i++) begin
			if (i < len) begin
				r[p] = v[i];
				p = (p % 8 == 7) ? p - 15 : p + 1;
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] get_field(input logic [63:0] d, input int start,
		input int len);
		logic [15:0] r;
		int p;
		r = '0;
		p = start;
		for (int i = 0; i < 16; i++) begin
			if (i < len) begin
				r[i] = d[p];
				p = (p % 8 == 7) ? p - 15 : p + 1;
			end
		end
		return r;
	endfunction

	// object fifo
	logic fifo_valid;
	logic fifo_ready;
	logic [rox_pkg::OBJ_W-1:0] fifo_data;
	wire [rox_pkg::OBJ_W-1:0] obj_word = {track_identifier_in, long_rel_accel_in,
		obj_class_in, lat_rel_accel_in, heading_angle_in, obj_length_in,
		obj_width_in, collision_region_mask_in};

	rox_fifo #(
		.WIDTH(rox_pkg::OBJ_W),
		.DEPTH(rox_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.in_valid_in(obj_valid_in),
		.in_ready_out(obj_ready_out),
		.in_data_in(obj_word),
		.out_valid_out(fifo_valid),
		.out_ready_in(fifo_ready),
		.out_data_out(fifo_data)
	);

	// transmit sequencer
	rox_pkg::rox_state_t state;
	logic [rox_pkg::OBJ_W-1:0] obj;
	logic ext_en_q;
	logic coll_en_q;
	logic tx_valid;
	logic [10:0] tx_id;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data;

	logic [7:0] o_id;
	logic [10:0] o_long;
	logic [2:0] o_class;
	logic [8:0] o_lat;
	logic [9:0] o_head;
	logic [7:0] o_len;
	logic [7:0] o_wid;
	logic [7:0] o_mask;
	assign {o_id, o_long, o_class, o_lat, o_head, o_len, o_wid, o_mask} = obj;

	wire [63:0] ep0 = put_field(64'h0, rox_pkg::ID_START, rox_pkg::ID_LEN,
		{8'h00, o_id});
	wire [63:0] ep1 = put_field(ep0, rox_pkg::LONG_START, rox_pkg::LONG_LEN,
		{5'h00, o_long});
	wire [63:0] ep2 = put_field(ep1, rox_pkg::CLASS_START, rox_pkg::CLASS_LEN,
		{13'h0000, o_class});
	wire [63:0] ep3 = put_field(ep2, rox_pkg::LAT_START, rox_pkg::LAT_LEN,
		{7'h00, o_lat});
	wire [63:0] ep4 = put_field(ep3, rox_pkg::HEAD_START, rox_pkg::HEAD_LEN,
		{6'h00, o_head});
	wire [63:0] ep5 = put_field(ep4, rox_pkg::LEN_START, rox_pkg::LEN_LEN,
		{8'h00, o_len});
	wire [63:0] ext_payload = put_field(ep5, rox_pkg::WID_START, rox_pkg::WID_LEN,
		{8'h00, o_wid});
	wire [63:0] warn_payload = put_field(ep0, rox_pkg::MASK_START,
		rox_pkg::MASK_LEN, {8'h00, o_mask});

	wire tx_take = tx_valid && tx_ready_in;
	// take a new object only when nothing is in flight; this costs two idle
	// cycles (ST_IDLE and ST_LOAD) per object but keeps the payload registers single-sourced
	assign fifo_ready = (state == rox_pkg::ST_IDLE);
	wire pop = fifo_valid && fifo_ready;
	wire load_ext = (state == rox_pkg::ST_LOAD) && ext_en_q;
	wire load_warn_first = (state == rox_pkg::ST_LOAD) && !ext_en_q && coll_en_q;
	wire load_warn_next = (state == rox_pkg::ST_EXT) && tx_take && coll_en_q;
	wire load_warn = load_warn_first || load_warn_next;
	wire tx_done = tx_take && ((state == rox_pkg::ST_WARN) || !coll_en_q);

	rox_pkg::rox_state_t next_state;
	always_comb begin
		next_state = state;
		unique case (state)
			rox_pkg::ST_IDLE: begin
				if (pop) begin
					next_state = rox_pkg::ST_LOAD;
				end
			end
			rox_pkg::ST_LOAD: begin
				if (load_ext) begin
					next_state = rox_pkg::ST_EXT;
				end else if (load_warn_first) begin
					next_state = rox_pkg::ST_WARN;
				end else begin
					next_state = rox_pkg::ST_IDLE;
				end
			end
			rox_pkg::ST_EXT: begin
				if (load_warn_next) begin
					next_state = rox_pkg::ST_WARN;
				end else if (tx_take) begin
					next_state = rox_pkg::ST_IDLE;
				end
			end
			rox_pkg::ST_WARN: begin
				if (tx_take) begin
					next_state = rox_pkg::ST_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= rox_pkg::ST_IDLE;
			obj <= '0;
			ext_en_q <= 1'b0;
			coll_en_q <= 1'b0;
		end else begin
			state <= next_state;
			if (pop) begin
				// enables are sampled per object so a frame pair stays consistent
				obj <= fifo_data;
				ext_en_q <= ext_info_send_enable_in;
				coll_en_q <= coll_det_enable_in;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			tx_valid <= 1'b0;
			tx_id <= '0;
			tx_dlc <= '0;
			tx_data <= '0;
		end else if (load_ext) begin
			tx_valid <= 1'b1;
			tx_id <= rox_pkg::EXT_FRAME_ID;
			tx_dlc <= rox_pkg::EXT_DLC;
			tx_data <= ext_payload;
		end else if (load_warn) begin
			tx_valid <= 1'b1;
			tx_id <= rox_pkg::WARN_FRAME_ID;
			tx_dlc <= rox_pkg::WARN_DLC;
			tx_data <= warn_payload;
		end else if (tx_done) begin
			tx_valid <= 1'b0;
		end
	end
	assign tx_valid_out = tx_valid;
	assign tx_id_out = tx_id;
	assign tx_dlc_out = tx_dlc;
	assign tx_data_out = tx_data;

	// receive decoder
	wire rx_is_ext = rx_valid_in && (rx_id_in == rox_pkg::EXT_FRAME_ID);
	wire rx_is_warn = rx_valid_in && (rx_id_in == rox_pkg::WARN_FRAME_ID);
	wire [15:0] f_id = get_field(rx_data_in, rox_pkg::ID_START, rox_pkg::ID_LEN);
	wire [15:0] f_long = get_field(rx_data_in, rox_pkg::LONG_START, rox_pkg::LONG_LEN);
	wire [15:0] f_class = get_field(rx_data_in, rox_pkg::CLASS_START, rox_pkg::CLASS_LEN);
	wire [15:0] f_lat = get_field(rx_data_in, rox_pkg::LAT_START, rox_pkg::LAT_LEN);
	wire [15:0] f_head = get_field(rx_data_in, rox_pkg::HEAD_START, rox_pkg::HEAD_LEN);
	wire [15:0] f_len = get_field(rx_data_in, rox_pkg::LEN_START, rox_pkg::LEN_LEN);
	wire [15:0] f_wid = get_field(rx_data_in, rox_pkg::WID_START, rox_pkg::WID_LEN);
	wire [15:0] f_mask = get_field(rx_data_in, rox_pkg::MASK_START, rox_pkg::MASK_LEN);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			rx_ext_valid_out <= 1'b0;
			rx_warn_valid_out <= 1'b0;
			rx_track_identifier_out <= '0;
			rx_long_rel_accel_out <= '0;
			rx_obj_class_out <= '0;
			rx_lat_rel_accel_out <= '0;
			rx_heading_angle_out <= '0;
			rx_obj_length_out <= '0;
			rx_obj_width_out <= '0;
			rx_collision_region_mask_out <= '0;
		end else begin
			rx_ext_valid_out <= rx_is_ext;
			rx_warn_valid_out <= rx_is_warn;
			if (rx_is_ext || rx_is_warn) begin
				rx_track_identifier_out <= f_id[7:0];
			end
			if (rx_is_ext) begin
				rx_long_rel_accel_out <= f_long[10:0];
				rx_obj_class_out <= f_class[2:0];
				rx_lat_rel_accel_out <= f_lat[8:0];
				rx_heading_angle_out <= f_head[9:0];
				rx_obj_length_out <= f_len[7:0];
				rx_obj_width_out <= f_wid[7:0];
			end
			if (rx_is_warn) begin
				rx_collision_region_mask_out <= f_mask[7:0];
			end
		end
	end

	// quality code lookup, upper half of the table only
	wire q_in = (qual_code_in >= rox_pkg::QUAL_FIRST) && (qual_code_in <= rox_pkg::QUAL_LAST);
	wire [4:0] q_idx = qual_code_in - rox_pkg::QUAL_FIRST;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			qual_heading_bound_out <= '0;
			qual_other_bound_out <= '0;
			qual_in_table_out <= 1'b0;
			qual_invalid_out <= 1'b0;
		end else begin
			qual_in_table_out <= q_in;
			qual_invalid_out <= (qual_code_in == rox_pkg::QUAL_INVALID);
			qual_heading_bound_out <= q_in ? rox_pkg::QB_HEAD[q_idx] : '0;
			qual_other_bound_out <= q_in ? rox_pkg::QB_OTHER[q_idx] : '0;
		end
	end

	a_ext_needs_enable: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID) |-> ext_en_q)
		else $error("extended frame sent while disabled");
	a_ext_per_object: assert property (@(posedge clk_in) disable iff (rst_in)
		pop && ext_info_send_enable_in |-> ##2 tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID))
		else $error("object without extended frame");
	a_tx_frame_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && !tx_ready_in |=> tx_valid && $stable(tx_data) && $stable(tx_id))
		else $error("frame dropped before acceptance");
	a_warn_follows_ext: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_take && (tx_id == rox_pkg::EXT_FRAME_ID) && coll_en_q
		|=> tx_valid && (tx_id == rox_pkg::WARN_FRAME_ID))
		else $error("warning frame missing after extended frame");
	a_warn_needs_enable: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::WARN_FRAME_ID) |-> coll_en_q)
		else $error("warning frame sent while detection off");
	a_tx_track_id: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid |-> (tx_data[7:0] == o_id))
		else $error("track id misplaced");
	a_long_bits: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID)
		|-> (tx_data[23:21] == o_long[2:0]) && (tx_data[15:8] == o_long[10:3]))
		else $error("longitudinal acceleration misplaced");
	a_class_bits: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID) |-> (tx_data[26:24] == o_class))
		else $error("object class misplaced");
	a_lat_bits: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID)
		|-> (tx_data[31:28] == o_lat[3:0]) && (tx_data[20:16] == o_lat[8:4]))
		else $error("lateral acceleration misplaced");
	a_len_wid_bytes: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID)
		|-> (tx_data[55:48] == o_len) && (tx_data[63:56] == o_wid))
		else $error("length or width misplaced");
	a_heading_bits: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::EXT_FRAME_ID)
		|-> (tx_data[47:46] == o_head[1:0]) && (tx_data[39:32] == o_head[9:2]))
		else $error("heading misplaced");
	a_mask_byte: assert property (@(posedge clk_in) disable iff (rst_in)
		tx_valid && (tx_id == rox_pkg::WARN_FRAME_ID) |-> (tx_data[15:8] == o_mask))
		else $error("region mask misplaced");
	a_rx_class: assert property (@(posedge clk_in) disable iff (rst_in)
		rx_is_ext |=> rx_ext_valid_out && (rx_obj_class_out == $past(rx_data_in[26:24])))
		else $error("class decode wrong");
	a_qual_invalid: assert property (@(posedge clk_in) disable iff (rst_in)
		(qual_code_in == 5'h1f) |=> qual_invalid_out && !qual_in_table_out)
		else $error("invalid code not flagged");
	a_qual_code_10: assert property (@(posedge clk_in) disable iff (rst_in)
		(qual_code_in == 5'h10) |=> (qual_heading_bound_out == 18'h00542)
		&& (qual_other_bound_out == 14'h0120))
		else $error("code 10 bound wrong");
endmodule

//--- tb/rox_host_model.sv
// host-side model of the can sink: takes frames promptly, with random stalls, or not at all
`timescale 1ns/1ps
module rox_host_model (
	input wire logic clk_in, // clock
	input wire logic [1:0] mode_in, // 0 prompt, 1 random stalls, 2 full stall
	output logic tx_ready_out // sink accepts the offered frame
);
	logic [15:0] lfsr = 16'hace1;
	initial tx_ready_out = 1'b0;
	// ready moves just after the edge so the codec never sees it change at its sampling point
	always @(posedge clk_in) begin
		lfsr <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		tx_ready_out <= #1 (mode_in == 2'h0) || (mode_in == 2'h1 && lfsr[0]);
	end
endmodule

//--- tb/rox_codec_tb.sv
// self-checking testbench for the radar object frame codec
`timescale 1ns/1ps
module radar_object_ext_frame_codec_tb_top;
	logic clk_in = 0, rst_in = 1, ext_en = 0, coll_en = 0, obj_valid = 0, rx_valid = 0;
	logic [7:0] tid = 0, len = 0, wid = 0, mask = 0;
	logic [10:0] lacc = 0, rx_id = 0;
	logic [2:0] cls = 0;
	logic [8:0] tacc = 0;
	logic [9:0] head = 0;
	logic [63:0] rx_data = 0;
	logic [4:0] qcode = 0;
	logic [1:0] host_mode = 0;
	logic obj_ready, tx_valid, tx_ready, rx_ev, rx_wv, q_in, q_inv;
	logic [10:0] tx_id, r_lacc;
	logic [3:0] tx_dlc;
	logic [63:0] tx_data;
	logic [7:0] r_tid, r_len, r_wid, r_mask;
	logic [2:0] r_cls;
	logic [8:0] r_tacc;
	logic [9:0] r_head;
	logic [17:0] q_head;
	logic [13:0] q_oth;
	logic [78:0] exq[$];
	logic [64:0] ef = 0;
	logic [31:0] seed = 32'h19e2;
	int n_errors = 0, n_compared = 0, cycles = 0, acc;
	int qh[18] = '{471, 669, 949, 1346, 1909, 2709, 3843, 5451, 7734, 10971, 15565,
		22081, 31325, 44439, 63044, 89437, 126881, 180000};
	int qo[18] = '{135, 174, 224, 288, 371, 478, 616, 794, 1023, 1317, 1697, 2187,
		2817, 3630, 4676, 6025, 7762, 10000};

	rox_codec rox_codec_inst (.clk_in(clk_in), .rst_in(rst_in),
		.ext_info_send_enable_in(ext_en), .coll_det_enable_in(coll_en),
		.obj_valid_in(obj_valid), .obj_ready_out(obj_ready), .track_identifier_in(tid),
		.long_rel_accel_in(lacc), .obj_class_in(cls), .lat_rel_accel_in(tacc),
		.heading_angle_in(head), .obj_length_in(len), .obj_width_in(wid),
		.collision_region_mask_in(mask), .tx_valid_out(tx_valid), .tx_ready_in(tx_ready),
		.tx_id_out(tx_id), .tx_dlc_out(tx_dlc), .tx_data_out(tx_data),
		.rx_valid_in(rx_valid), .rx_id_in(rx_id), .rx_data_in(rx_data),
		.rx_ext_valid_out(rx_ev), .rx_warn_valid_out(rx_wv),
		.rx_track_identifier_out(r_tid), .rx_long_rel_accel_out(r_lacc),
		.rx_obj_class_out(r_cls), .rx_lat_rel_accel_out(r_tacc),
		.rx_heading_angle_out(r_head), .rx_obj_length_out(r_len),
		.rx_obj_width_out(r_wid), .rx_collision_region_mask_out(r_mask),
		.qual_code_in(qcode), .qual_heading_bound_out(q_head),
		.qual_other_bound_out(q_oth), .qual_in_table_out(q_in), .qual_invalid_out(q_inv));
	rox_host_model rox_host_model_inst (.clk_in(clk_in), .mode_in(host_mode),
		.tx_ready_out(tx_ready));

	initial begin
		forever #20 clk_in = ~clk_in;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	// field lsb sits at its start bit, grows upward in the byte, then wraps to the byte below
	function automatic logic [63:0] put(logic [63:0] d, int s, int n, logic [15:0] v);
		int p;
		p = s;
		for (int i = 0; i < n; i++) begin
			d[p] = v[i];
			p = (p % 8 == 7) ? p - 15 : p + 1;
		end
		return d;
	endfunction

	function automatic logic [15:0] get(logic [63:0] d, int s, int n);
		int p;
		logic [15:0] v;
		p = s;
		v = 0;
		for (int i = 0; i < n; i++) begin
			v[i] = d[p];
			p = (p % 8 == 7) ? p - 15 : p + 1;
		end
		return v;
	endfunction

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	task automatic check(input logic [79:0] got, input logic [79:0] exp, input string msg);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: %s", $time, msg);
		end
	endtask

	task automatic pick(input int i);
		logic [31:0] r;
		r = rnd();
		tid = r[7:0];
		lacc = r[18:8];
		tacc = r[27:19];
		r = rnd();
		head = r[9:0];
		len = r[17:10];
		wid = r[25:18];
		r = rnd();
		mask = r[7:0];
		cls = i[2:0];
	endtask

	task automatic expect_obj();
		logic [63:0] d;
		d = put(64'h0, 0, 8, tid);
		d = put(d, 21, 11, lacc);
		d = put(d, 24, 3, cls);
		d = put(d, 28, 9, tacc);
		d = put(d, 46, 10, head);
		d = put(d, 48, 8, len);
		d = put(d, 56, 8, wid);
		if (ext_en) exq.push_back({11'h60d, 4'h8, d});
		if (coll_en) exq.push_back({11'h60e, 4'h2, put(put(64'h0, 0, 8, tid), 8, 8, mask)});
	endtask

	task automatic send(input int i);
		pick(i);
		obj_valid = 1;
		do @(posedge clk_in); while (obj_ready !== 1'b1);
		expect_obj();
		#1;
	endtask

	// enables are sampled at pop, so let every stored object leave before they change
	task automatic drain();
		obj_valid = 0;
		for (int k = 0; k < 1000 && exq.size() != 0; k++) @(posedge clk_in);
		repeat (80) @(posedge clk_in);
		#1;
		check(exq.size(), 0, "frames missing");
		check(tx_valid, 0, "frame offered after drain");
	endtask

	always @(posedge clk_in) begin
		if (!rst_in && tx_valid === 1'b1 && tx_ready === 1'b1) begin
			if (exq.size() == 0) check(1, 0, "unexpected frame");
			else check({tx_id, tx_dlc, tx_data}, exq.pop_front(), "frame content");
		end
	end

	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			$display("CHECK FAILED at %0t: timeout", $time);
			summarize();
		end
	end

	initial begin
		logic [31:0] r;
		logic e_ev, e_wv;
		repeat (8) @(posedge clk_in);
		#1;
		rst_in = 0;
		check({tx_valid, obj_ready, rx_ev, rx_wv, q_in, q_inv}, 6'h10, "reset outputs");
		$display("test reset done");
		for (int m = 0; m < 4; m++) begin
			ext_en = m[0];
			coll_en = m[1];
			host_mode = {1'b0, m[1]};
			for (int i = 0; i < 20; i++) send(i);
			drain();
			$display("test frames mode %0d done", m);
		end
		ext_en = 1;
		coll_en = 1;
		host_mode = 2;
		acc = 0;
		pick(0);
		obj_valid = 1;
		for (int k = 0; k < 40; k++) begin
			@(posedge clk_in);
			if (obj_ready !== 1'b1) break;
			expect_obj();
			acc++;
			#1;
			pick(k + 1);
		end
		#1;
		check(obj_ready, 0, "full fifo still ready");
		check(acc >= 16, 1, "fifo held too few objects");
		host_mode = 1;
		drain();
		$display("test fifo full done");
		for (int i = 0; i < 60; i++) begin
			r = rnd();
			rx_id = (r[1:0] == 2'h0) ? r[14:4] : (r[0] ? 11'h60d : 11'h60e);
			rx_valid = r[2] | r[3];
			rx_data = {rnd(), rnd()};
			@(posedge clk_in);
			e_ev = rx_valid && rx_id == 11'h60d;
			e_wv = rx_valid && rx_id == 11'h60e;
			if (e_ev || e_wv) ef[64:57] = 8'(get(rx_data, 0, 8));
			if (e_ev) begin
				ef[56:46] = 11'(get(rx_data, 21, 11));
				ef[45:43] = 3'(get(rx_data, 24, 3));
				ef[42:34] = 9'(get(rx_data, 28, 9));
				ef[33:24] = 10'(get(rx_data, 46, 10));
				ef[23:16] = 8'(get(rx_data, 48, 8));
				ef[15:8] = 8'(get(rx_data, 56, 8));
			end
			if (e_wv) ef[7:0] = 8'(get(rx_data, 8, 8));
			#1;
			check({rx_ev, rx_wv}, {e_ev, e_wv}, "receive pulse");
			check({r_tid, r_lacc, r_cls, r_tacc, r_head, r_len, r_wid, r_mask}, ef,
				"decoded fields");
		end
		rx_valid = 0;
		$display("test receive done");
		for (int c = 0; c < 32; c++) begin
			qcode = c[4:0];
			@(posedge clk_in);
			#1;
			if (c >= 13 && c <= 30) check({q_in, q_inv, q_head, q_oth},
				{2'b10, 18'(qh[c - 13]), 14'(qo[c - 13])}, "quality bound");
			else check({q_in, q_inv, q_head, q_oth}, {1'b0, c == 31, 32'h0},
				"quality code outside table");
		end
		$display("test quality done");
		summarize();
	end
endmodule
